/* File: ctr_array_pkg.sv */
// constants for the counter array mode control block
// Functional notes
// - mode bit 7 picks 16-bit PWM, else 8 to 15-bit PWM
// - mode bit 6 enables comparing counter against module value
// - mode bit 5 captures counter on rising pin edge
// - mode bit 4 captures counter on falling pin edge; both may be set
// - mode bit 3 sets module event flag when counter equals value
// - mode bit 2 inverts module pin on each match
// - toggle plus PWM together select frequency output mode
// - mode bit 1 drives PWM waveform on pin at selected width
// - mode bit 0 lets the event flag raise an interrupt request
// - watchdog enable blocks module 2 mode writes; module 2 is watchdog
// - three 8-bit mode registers at distinct addresses, reset to zero
// - counter low byte register reads and writes counter bits 7:0
// - watchdog enable makes counter low byte writes ineffective
// - low byte read latches high byte snapshot; high byte read returns it
// - cycle length field sets PWM length 8 to 15 bits
// - value low write clears comparator enable; high write sets it
package ctr_array_pkg;
  localparam int NUM_MOD = 3;
  localparam int SFR_AW = 8;
  localparam int SFR_DW = 8;
  localparam int CNT_W = 16;
  localparam int CLS_W = 3;
  localparam int WDT_MOD = 2;
  // register addresses
  localparam logic [SFR_AW-1:0] ADDR_CMODE = 8'hd9;
  localparam logic [SFR_AW-1:0] ADDR_CNT_LO = 8'hf9;
  localparam logic [SFR_AW-1:0] ADDR_CNT_HI = 8'hfa;
  localparam logic [NUM_MOD-1:0][SFR_AW-1:0] ADDR_MODE = {8'hdc, 8'hdb, 8'hda};
  localparam logic [NUM_MOD-1:0][SFR_AW-1:0] ADDR_VLO = {8'heb, 8'he9, 8'hfb};
  localparam logic [NUM_MOD-1:0][SFR_AW-1:0] ADDR_VHI = {8'hec, 8'hea, 8'hfc};
  // module mode register bits
  localparam int B_WIDE = 7;
  localparam int B_ECOM = 6;
  localparam int B_RISE = 5;
  localparam int B_FALL = 4;
  localparam int B_MAT = 3;
  localparam int B_TOG = 2;
  localparam int B_PWM = 1;
  localparam int B_IRQ = 0;
  // counter mode register fields (flags sit in bits NUM_MOD-1:0)
  localparam int CM_RUN = 7;
  localparam int CM_WATCHDOG_ENABLE_BIT = 6;
  localparam int CM_CLS_LSB = 3;
  // reset values and constants
  localparam logic [SFR_DW-1:0] MODE_RST = 8'h00;
  localparam logic [SFR_DW-1:0] CMODE_RST = 8'h00;
  localparam logic [SFR_DW-1:0] RD_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] PWM_BASE_MASK = 16'h00ff;
endpackage

/* File: ccm_if.sv */
// signals between the control block and one capture/compare unit
`timescale 1ns/10ps
interface ccm_if;
  logic [15:0] counter;
  logic [7:0] mode;
  logic [15:0] value;
  logic [2:0] cls;
  logic pin_in;
  logic ev;
  logic cap;
  logic pin_out;
  logic pin_oe;
  modport unit (input counter, mode, value, cls, pin_in, output ev, cap, pin_out, pin_oe);
  modport ctrl (output counter, mode, value, cls, pin_in, input ev, cap, pin_out, pin_oe);
endinterface

/* File: capture_compare_unit.sv */
// one capture/compare module: edge capture, match, toggle, pwm, frequency out
`timescale 1ns/10ps
module capture_compare_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link to control block
  ccm_if.unit bus
);
  import ctr_array_pkg::*;

  typedef struct packed {
    logic pin;
    logic prev;
  } unit_s;

  unit_s s_q;
  unit_s s_d;
  logic [CNT_W-1:0] mask;
  logic hit;
  logic fhit;
  logic rise;
  logic fall;
  logic pwm_lvl;

  // match, edge and waveform decisions
  always_comb begin
    s_d = s_q;
    mask = 16'((PWM_BASE_MASK << bus.cls) | PWM_BASE_MASK);
    hit = bus.mode[B_ECOM] && (bus.counter == bus.value);
    fhit = bus.mode[B_ECOM] && (bus.counter[7:0] == bus.value[7:0]);
    rise = bus.pin_in & ~s_q.prev;
    fall = ~bus.pin_in & s_q.prev;
    if (bus.mode[B_WIDE]) begin
      pwm_lvl = bus.counter < bus.value;
    end else begin
      pwm_lvl = (bus.counter & mask) < (bus.value & mask);
    end
    s_d.prev = bus.pin_in;
    if (bus.mode[B_PWM] && bus.mode[B_TOG]) begin
      if (fhit) begin
        s_d.pin = ~s_q.pin;
      end
    end else if (bus.mode[B_PWM]) begin
      s_d.pin = pwm_lvl;
    end else if (bus.mode[B_TOG] && hit) begin
      s_d.pin = ~s_q.pin;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // capture strobe and event to the control block
  assign bus.cap = (bus.mode[B_RISE] & rise) | (bus.mode[B_FALL] & fall);
  assign bus.ev = bus.cap | (bus.mode[B_MAT] & hit);
  assign bus.pin_out = s_q.pin;
  assign bus.pin_oe = bus.mode[B_TOG] | bus.mode[B_PWM];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_toggle_on_match: assert property (bus.mode[B_TOG] && !bus.mode[B_PWM] && hit |=> bus.pin_out != $past(bus.pin_out))
    else $error("pin did not invert on match");
  a_pwm_wide_level: assert property (bus.mode[B_PWM] && !bus.mode[B_TOG] && bus.mode[B_WIDE]
    |=> bus.pin_out == $past(bus.counter < bus.value))
    else $error("wide pwm level wrong");
  a_capture_rise: assert property (bus.mode[B_RISE] && bus.pin_in && !$past(bus.pin_in) |-> bus.cap && bus.ev)
    else $error("rising edge not captured");
  a_capture_fall: assert property (bus.mode[B_FALL] && !bus.pin_in && $past(bus.pin_in) |-> bus.cap && bus.ev)
    else $error("falling edge not captured");
endmodule // capture_compare_unit

/* File: counter_array_module_mode_ctrl.sv */
// counter array mode control: register file, counter, snapshot, watchdog lock
`timescale 1ns/10ps
module counter_array_module_mode_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // special function register bus
  input wire logic [ctr_array_pkg::SFR_AW-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [ctr_array_pkg::SFR_DW-1:0] sfr_wdata,
  output logic [ctr_array_pkg::SFR_DW-1:0] sfr_rdata,
  // module pins, split into input, output and enable
  input wire logic [ctr_array_pkg::NUM_MOD-1:0] module_io_pin_in,
  output logic [ctr_array_pkg::NUM_MOD-1:0] module_io_pin_out,
  output logic [ctr_array_pkg::NUM_MOD-1:0] module_io_pin_oe,
  // requests
  output logic module_irq,
  output logic wdt_reset
);
  import ctr_array_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [SFR_DW-1:0] snap;
    logic [NUM_MOD-1:0][SFR_DW-1:0] mode;
    logic [NUM_MOD-1:0][CNT_W-1:0] val;
    logic [SFR_DW-1:0] cmode;
    logic [SFR_DW-1:0] rdata;
    logic [NUM_MOD-1:0] sync1;
    logic [NUM_MOD-1:0] sync2;
    logic wdt;
  } top_s;

  top_s s_q;
  top_s s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic watchdog_enable_bit;
  logic [NUM_MOD-1:0] ev_w;
  logic [NUM_MOD-1:0] cap_w;
  logic [NUM_MOD-1:0] irq_en;

  ccm_if ch[NUM_MOD] ();

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // one capture/compare unit per module
  generate
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
      assign ch[g].counter = s_q.cnt;
      assign ch[g].mode = s_q.mode[g];
      assign ch[g].value = s_q.val[g];
      assign ch[g].cls = s_q.cmode[CM_CLS_LSB +: CLS_W];
      assign ch[g].pin_in = s_q.sync2[g];
      assign ev_w[g] = ch[g].ev;
      assign cap_w[g] = ch[g].cap;
      assign irq_en[g] = s_q.mode[g][B_IRQ];
      assign module_io_pin_out[g] = ch[g].pin_out;
      assign module_io_pin_oe[g] = ch[g].pin_oe;

      capture_compare_unit u_unit (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(ch[g])
      );
    end
  endgenerate

  assign watchdog_enable_bit = s_q.cmode[CM_WATCHDOG_ENABLE_BIT];

  // next state: counter, bus writes, captures, flags, reads
  always_comb begin
    s_d = s_q;
    // pin synchronisers
    s_d.sync1 = module_io_pin_in;
    s_d.sync2 = s_q.sync1;
    // counter runs on the system clock while enabled
    if (s_q.cmode[CM_RUN]) begin
      s_d.cnt = 16'(s_q.cnt + CNT_STEP);
    end
    // shared register writes
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_CMODE: begin
          s_d.cmode = sfr_wdata;
        end
        ADDR_CNT_LO: begin
          if (!watchdog_enable_bit) begin
            s_d.cnt[7:0] = sfr_wdata;
          end
        end
        ADDR_CNT_HI: begin
          if (!watchdog_enable_bit) begin
            s_d.cnt[15:8] = sfr_wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // per-module registers
    for (int i = 0; i < NUM_MOD; i++) begin
      if (cap_w[i]) begin
        s_d.val[i] = s_q.cnt;
      end
      if (sfr_wr && !(i == WDT_MOD && watchdog_enable_bit)) begin
        if (sfr_addr == ADDR_MODE[i]) begin
          s_d.mode[i] = sfr_wdata;
        end
        if (sfr_addr == ADDR_VLO[i]) begin
          s_d.val[i][7:0] = sfr_wdata;
          s_d.mode[i][B_ECOM] = 1'b0;
        end
        if (sfr_addr == ADDR_VHI[i]) begin
          s_d.val[i][15:8] = sfr_wdata;
          s_d.mode[i][B_ECOM] = 1'b1;
        end
      end
      // event sets its flag; a set in the clearing cycle wins
      s_d.cmode[i] = s_d.cmode[i] | ev_w[i];
    end
    // watchdog fires when the counter high byte reaches module 2's high value
    s_d.wdt = watchdog_enable_bit && (s_q.cnt[15:8] == s_q.val[WDT_MOD][15:8]);
    // read data, registered
    if (sfr_rd) begin
      s_d.rdata = RD_ZERO;
      case (sfr_addr)
        ADDR_CMODE: begin
          s_d.rdata = s_q.cmode;
        end
        ADDR_CNT_LO: begin
          s_d.rdata = s_q.cnt[7:0];
          s_d.snap = s_q.cnt[15:8];
        end
        ADDR_CNT_HI: begin
          s_d.rdata = s_q.snap;
        end
        default: begin
        end
      endcase
      for (int i = 0; i < NUM_MOD; i++) begin
        if (sfr_addr == ADDR_MODE[i]) begin
          s_d.rdata = s_q.mode[i];
        end
        if (sfr_addr == ADDR_VLO[i]) begin
          s_d.rdata = s_q.val[i][7:0];
        end
        if (sfr_addr == ADDR_VHI[i]) begin
          s_d.rdata = s_q.val[i][15:8];
        end
      end
    end
  end

  // state register, all fields cleared by reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign sfr_rdata = s_q.rdata;
  assign module_irq = |(s_q.cmode[NUM_MOD-1:0] & irq_en);
  assign wdt_reset = s_q.wdt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_low;
    sfr_rd && sfr_addr == ADDR_CNT_LO;
  endsequence

  sequence s_rd_high;
    sfr_rd && sfr_addr == ADDR_CNT_HI;
  endsequence

  sequence s_wr_mode0;
    sfr_wr && sfr_addr == ADDR_MODE[0];
  endsequence

  a_mode_write_lands: assert property (s_wr_mode0 |=> s_q.mode[0] == $past(sfr_wdata))
    else $error("mode 0 write did not land on the next edge");
  a_mode2_locked: assert property (watchdog_enable_bit && sfr_wr && sfr_addr == ADDR_MODE[WDT_MOD]
    |=> s_q.mode[WDT_MOD] == $past(s_q.mode[WDT_MOD]))
    else $error("module 2 mode changed under watchdog");
  a_low_write_lands: assert property (!watchdog_enable_bit && sfr_wr && sfr_addr == ADDR_CNT_LO
    |=> s_q.cnt[7:0] == $past(sfr_wdata))
    else $error("counter low byte write lost");
  a_low_write_locked: assert property (watchdog_enable_bit && !s_q.cmode[CM_RUN] && sfr_wr && sfr_addr == ADDR_CNT_LO
    |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter changed by write under watchdog");
  a_snapshot_latch: assert property (s_rd_low |=> s_q.snap == $past(s_q.cnt[15:8]))
    else $error("low byte read did not latch the high byte");
  a_snapshot_path: assert property (s_rd_high |=> sfr_rdata == $past(s_q.snap))
    else $error("high byte read did not return snapshot");
  a_value_low_ecom: assert property (sfr_wr && sfr_addr == ADDR_VLO[0] |=> !s_q.mode[0][B_ECOM])
    else $error("value low write left comparator enabled");
  a_value_high_ecom: assert property (sfr_wr && sfr_addr == ADDR_VHI[0] |=> s_q.mode[0][B_ECOM])
    else $error("value high write left comparator disabled");
  a_match_flag: assert property (s_q.mode[0][B_MAT] && s_q.mode[0][B_ECOM] && s_q.cnt == s_q.val[0]
    |=> s_q.cmode[0])
    else $error("match did not set event flag");
  a_irq_masking: assert property (s_q.cmode[0] && s_q.mode[0][B_IRQ] |-> module_irq)
    else $error("interrupt request missing for an enabled flag");
  a_irq_quiet: assert property ((s_q.cmode[NUM_MOD-1:0] & irq_en) == '0 |-> !module_irq)
    else $error("interrupt request raised with no enabled flag");
endmodule // counter_array_module_mode_ctrl

/* File: pin_stim_model.sv */
// far-side model: drives the capture input pins of the three modules
`timescale 1ns/10ps
module pin_stim_model (
  // clock
  input wire logic ref_clk,
  // pin levels driven toward the block
  output logic [2:0] pin_lvl
);
  logic [2:0] req_q;
  // requested levels reach the pins just after a rising edge
  initial begin
    req_q = 3'h0;
    pin_lvl = 3'h0;
  end
  always @(posedge ref_clk) begin
    pin_lvl <= req_q;
  end
  // bench asks for new pin levels here
  task automatic set_pins(input logic [2:0] v);
    req_q = v;
  endtask
endmodule // pin_stim_model

/* File: counter_array_module_mode_ctrl_tb.sv */
// self-checking bench for the counter array mode control block
`timescale 1ns/10ps
module counter_array_module_mode_ctrl_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [2:0] pin_in, pin_out, pin_oe, pin_lvl;
  logic module_irq, wdt_reset;
  int failures = 0;
  int comparisons = 0;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  // wire level: module drive wins while its enable is high
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_lvl);
  counter_array_module_mode_ctrl dut_u (.ref_clk(ref_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .module_io_pin_in(pin_in),
    .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .module_irq(module_irq), .wdt_reset(wdt_reset));
  pin_stim_model pins_u (.ref_clk(ref_clk), .pin_lvl(pin_lvl));
  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register write, strobe held for one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one register read compared against the expected byte
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
    chk($sformatf("reg %h", a), exp, sfr_rdata);
  endtask
  // count high pin samples of module 0 over n cycles
  task automatic pwm_count(input int n, output int highs);
    highs = 0;
    repeat (n) begin
      @(posedge ref_clk);
      highs += (pin_out[0] === 1'b1);
    end
  endtask
  task automatic t_reset;
    rdc(8'hda, 8'h00);
    rdc(8'hdb, 8'h00);
    rdc(8'hdc, 8'h00);
    rdc(8'hf9, 8'h00);
    wr(8'hdb, 8'ha5);
    rdc(8'hdb, 8'ha5);
    $display("test reset done");
  endtask
  task automatic t_watchdog;
    wr(8'hd9, 8'h40);
    wr(8'hdc, 8'h55);
    rdc(8'hdc, 8'h00);
    wr(8'hf9, 8'h66);
    rdc(8'hf9, 8'h00);
    chk("wdt_reset", 8'h01, {7'h0, wdt_reset});
    wr(8'hd9, 8'h00);
    wr(8'hdc, 8'h55);
    rdc(8'hdc, 8'h55);
    wr(8'hdc, 8'h00);
    $display("test watchdog done");
  endtask
  task automatic t_capture;
    wr(8'hfa, 8'h12);
    wr(8'hf9, 8'h77);
    wr(8'hdb, 8'h21);
    wr(8'hdc, 8'h10);
    pins_u.set_pins(3'b100);
    repeat (6) @(posedge ref_clk);
    pins_u.set_pins(3'b010);
    repeat (6) @(posedge ref_clk);
    rdc(8'hd9, 8'h06);
    chk("irq", 8'h01, {7'h0, module_irq});
    rdc(8'he9, 8'h77);
    rdc(8'hea, 8'h12);
    rdc(8'hf9, 8'h77);
    wr(8'hfa, 8'h99);
    rdc(8'hfa, 8'h12);
    wr(8'hdb, 8'h20);
    chk("irq masked", 8'h00, {7'h0, module_irq});
    wr(8'hd9, 8'h00);
    $display("test capture done");
  endtask
  task automatic t_match;
    wr(8'hda, 8'h40);
    wr(8'hfb, 8'h10);
    rdc(8'hda, 8'h00);
    wr(8'hfc, 8'h00);
    rdc(8'hda, 8'h40);
    wr(8'hda, 8'h4d);
    wr(8'hfa, 8'h00);
    wr(8'hf9, 8'h00);
    wr(8'hd9, 8'h80);
    repeat (40) @(posedge ref_clk);
    chk("pin0", 8'h01, {7'h0, pin_out[0]});
    chk("oe0", 8'h01, {7'h0, pin_oe[0]});
    chk("irq", 8'h01, {7'h0, module_irq});
    rdc(8'hd9, 8'h81);
    wr(8'hd9, 8'h00);
    $display("test match done");
  endtask
  task automatic t_pwm;
    int highs;
    wr(8'hfb, 8'h80);
    wr(8'hfc, 8'h00);
    wr(8'hda, 8'h42);
    wr(8'hd9, 8'h80);
    pwm_count(256, highs);
    chk("pwm8 highs", 16'd128, highs[15:0]);
    wr(8'hd9, 8'h88);
    pwm_count(512, highs);
    chk("pwm9 highs", 16'd128, highs[15:0]);
    wr(8'hda, 8'hc2);
    pwm_count(256, highs);
    chk("pwm16 highs", 16'd0, highs[15:0]);
    // frequency output: pin inverts once per 256 counts, so half of 512 samples are high
    wr(8'hda, 8'h46);
    pwm_count(512, highs);
    chk("freq highs", 16'd256, highs[15:0]);
    wr(8'hd9, 8'h00);
    $display("test pwm done");
  endtask
  // hang guard
  initial begin
    repeat (6000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_watchdog;
    t_capture;
    t_match;
    t_pwm;
    end_sim;
  end
endmodule // counter_array_module_mode_ctrl_tb
